// File: rtl/timer_consts.svh
// Purpose: Offsets, field positions, reset values and timing figures of the two timers
// Assumes: Included by bare name from the prescaler, counter and timer block files
// Notes:   Definitions only
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

`define BASIC_MODE_OFF     8'hd8
`define BASIC_COUNT_OFF    8'hd9
`define TCA_MODE_OFF       8'hda
`define TCA_COUNT_OFF      8'hdb
`define TCA_RELOAD_OFF     8'hcd
`define IRQ_CTRL_OFF       8'hc9
`define RTC_PHASE_OFF      8'hce

`define BM_REALTIME_BIT    0
`define BM_TCA_GREEN_BIT   1
`define BM_TCA_FAST_BIT    2
`define BM_TCB_FAST_BIT    3
`define BM_RATE_LSB        4
`define BM_ENABLE_BIT      7

`define TM_PWM_BIT         0
`define TM_TOGGLE_BIT      1
`define TM_RELOAD_BIT      2
`define TM_RATE_LSB        4
`define TM_ENABLE_BIT      7
`define TM_RSVD_MASK       8'hf7

`define IRQ_BASIC_EN_BIT   0
`define IRQ_BASIC_REQ_BIT  1
`define IRQ_TCA_EN_BIT     2
`define IRQ_TCA_REQ_BIT    3

`define REG_RESET          8'h00
`define COUNT_TOP          8'hff

`define RTC_PERIOD_MS      500
`define LOW_CLK_HZ         32768
`define RTC_LOW_EDGES      ((`LOW_CLK_HZ * `RTC_PERIOD_MS) / 1000)

`endif

// File: rtl/timer_pkg.sv
// Purpose: Shared types and divisor decoding for the two timers
// Assumes: Nothing beyond the constants header
// Notes:   Rate code 000 is the slowest setting
package timer_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [2:0] rate_t;
	typedef logic [8:0] div_t;

	typedef enum logic [1:0] {
		span_full,
		span_half,
		span_quarter,
		span_eighth
	} pwm_span_t;

	// Divisor of a rate code; fast source is one octave quicker
	function automatic div_t rate_divisor(input rate_t rate, input logic fast);
		div_t base;
		base = fast ? 9'h080 : 9'h100;
		return div_t'(base >> rate);
	endfunction : rate_divisor

	// Last count before overflow for a pwm span
	function automatic byte_t span_top(input pwm_span_t span);
		byte_t top;
		top = 8'hff;
		case (span)
			span_full:    top = 8'hff;
			span_half:    top = 8'h7f;
			span_quarter: top = 8'h3f;
			span_eighth:  top = 8'h1f;
			default:      top = 8'hff;
		endcase
		return top;
	endfunction : span_top

endpackage : timer_pkg

// File: rtl/rate_prescaler.sv
// Purpose: Divides a source tick by a rate code into a counting step
// Assumes: src_tick_i is a one-cycle enable on ref_clk_i
// Notes:   Cleared while the timer is stopped so each start is aligned
`timescale 1ns/1ns
`include "timer_consts.svh"
module rate_prescaler (
	input  wire logic           ref_clk_i,
	input  wire logic           rst_i,
	input  wire logic           ce_i,
	input  wire logic           run_i,
	input  wire logic           src_tick_i,
	input  wire timer_pkg::rate_t rate_i,
	input  wire logic           fast_i,
	output logic                step_o
);
	import timer_pkg::*;

	div_t div_cnt_r;
	div_t div_last;

	assign div_last = rate_divisor(rate_i, fast_i) - 9'h001;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_r <= 9'h000;
			step_o    <= 1'b0;
		end else if (ce_i) begin
			step_o <= 1'b0;
			if (!run_i) begin
				div_cnt_r <= 9'h000;
			end else if (src_tick_i) begin
				// Compare with >= so a rate change mid-way cannot run past the end
				if (div_cnt_r >= div_last) begin
					div_cnt_r <= 9'h000;
					step_o    <= 1'b1;
				end else begin
					div_cnt_r <= div_cnt_r + 9'h001;
				end
			end
		end
	end

endmodule : rate_prescaler

// File: rtl/up_counter8.sv
// Purpose: 8-bit up counter with software load, wrap point and optional reload
// Assumes: step_i is a one-cycle enable on ref_clk_i
// Notes:   A software load in the same cycle as a wrap wins and drops that wrap
`timescale 1ns/1ns
`include "timer_consts.svh"
module up_counter8 (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             run_i,
	input  wire logic             step_i,
	input  wire logic             load_i,
	input  wire timer_pkg::byte_t load_val_i,
	input  wire timer_pkg::byte_t top_i,
	input  wire logic             reload_en_i,
	input  wire timer_pkg::byte_t reload_val_i,
	output timer_pkg::byte_t      count_o,
	output logic                  wrap_o
);
	import timer_pkg::*;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= `REG_RESET;
			wrap_o  <= 1'b0;
		end else if (ce_i) begin
			wrap_o <= 1'b0;
			if (load_i) begin
				count_o <= load_val_i;
			end else if (run_i && step_i) begin
				if (count_o >= top_i) begin
					count_o <= reload_en_i ? reload_val_i : 8'h00;
					wrap_o  <= 1'b1;
				end else begin
					count_o <= count_o + 8'h01;
				end
			end
		end
	end

endmodule : up_counter8

// File: rtl/timer_block.sv
// Purpose: Basic timer with real-time mode and timer/counter a with reload, toggle pin and pwm
// Assumes: cpu_tick_i and osc_tick_i are one-cycle enables on ref_clk_i; low_clk_i is an outside pin
// Notes:
`timescale 1ns/1ns
`include "timer_consts.svh"
module timer_block #(
	parameter int RTC_LOW_EDGES = `RTC_LOW_EDGES
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             cpu_tick_i,
	input  wire logic             osc_tick_i,
	input  wire logic             low_clk_i,
	input  wire logic             green_mode_i,
	input  wire timer_pkg::byte_t addr_i,
	input  wire timer_pkg::byte_t wdata_i,
	input  wire logic             we_i,
	input  wire logic             re_i,
	output timer_pkg::byte_t      rdata_o,
	output logic                  basic_irq_o,
	output logic                  tca_irq_o,
	output logic                  wake_o,
	output logic                  tcb_fast_clock_select_o,
	output logic                  toggle_output_pin_o,
	output logic                  toggle_output_pin_oe_o,
	output logic                  pwm_o
);
	import timer_pkg::*;

	localparam int RTC_W = (RTC_LOW_EDGES > 1) ? $clog2(RTC_LOW_EDGES) : 1;
	localparam logic [RTC_W-1:0] RTC_LAST = RTC_W'(RTC_LOW_EDGES - 1);

	generate
		if (RTC_LOW_EDGES < 2) begin : g_bad_rtc
			$error("RTC_LOW_EDGES must be at least 2");
		end
	endgenerate

	byte_t            basic_timer_mode_reg_r;
	byte_t            timer_counter_mode_reg_r;
	byte_t            tca_reload_reg_r;
	logic             basic_irq_enable_r;
	logic             basic_irq_request_r;
	logic             tca_irq_enable_r;
	logic             tca_irq_request_r;
	logic             low_sync1_r;
	logic             low_sync2_r;
	logic             low_prev_r;
	logic [RTC_W-1:0] rtc_phase_r;
	logic             rtc_timeout_r;
	logic             toggle_level_r;

	byte_t            basic_timer_count_reg;
	byte_t            tca_count_reg;
	byte_t            tca_top;
	logic             basic_step;
	logic             tca_step;
	logic             basic_wrap;
	logic             tca_wrap;
	logic             basic_timeout;
	logic             tca_timeout;
	logic             low_rise;
	logic             wr_basic_mode;
	logic             wr_basic_count;
	logic             wr_tca_mode;
	logic             wr_tca_count;
	logic             wr_tca_reload;
	logic             wr_irq;

	logic             realtime_select;
	logic             tca_green_wake_enable;
	logic             tca_fast_clock_select;
	rate_t            basic_rate_field;
	logic             basic_timer_enable;
	logic             tca_pwm_enable;
	logic             tca_toggle_output;
	logic             tca_auto_reload;
	rate_t            tca_rate_field;
	logic             tca_enable;
	pwm_span_t        tca_span;

	// Mode fields
	assign realtime_select       = basic_timer_mode_reg_r[`BM_REALTIME_BIT];
	assign tca_green_wake_enable = basic_timer_mode_reg_r[`BM_TCA_GREEN_BIT];
	assign tca_fast_clock_select = basic_timer_mode_reg_r[`BM_TCA_FAST_BIT];
	assign basic_rate_field      = basic_timer_mode_reg_r[`BM_RATE_LSB +: 3];
	assign basic_timer_enable    = basic_timer_mode_reg_r[`BM_ENABLE_BIT];
	assign tca_pwm_enable        = timer_counter_mode_reg_r[`TM_PWM_BIT];
	assign tca_toggle_output     = timer_counter_mode_reg_r[`TM_TOGGLE_BIT];
	assign tca_auto_reload       = timer_counter_mode_reg_r[`TM_RELOAD_BIT];
	assign tca_rate_field        = timer_counter_mode_reg_r[`TM_RATE_LSB +: 3];
	assign tca_enable            = timer_counter_mode_reg_r[`TM_ENABLE_BIT];
	assign tca_span              = pwm_span_t'({tca_auto_reload, tca_toggle_output});

	// Address decode
	always_comb begin
		wr_basic_mode  = 1'b0;
		wr_basic_count = 1'b0;
		wr_tca_mode    = 1'b0;
		wr_tca_count   = 1'b0;
		wr_tca_reload  = 1'b0;
		wr_irq         = 1'b0;
		if (!we_i) begin
			wr_irq = 1'b0;
		end else if (addr_i == `BASIC_MODE_OFF) begin
			wr_basic_mode = 1'b1;
		end else if (addr_i == `BASIC_COUNT_OFF) begin
			wr_basic_count = 1'b1;
		end else if (addr_i == `TCA_MODE_OFF) begin
			wr_tca_mode = 1'b1;
		end else if (addr_i == `TCA_COUNT_OFF) begin
			wr_tca_count = 1'b1;
		end else if (addr_i == `TCA_RELOAD_OFF) begin
			wr_tca_reload = 1'b1;
		end else if (addr_i == `IRQ_CTRL_OFF) begin
			wr_irq = 1'b1;
		end
	end

	// Mode and reload registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			basic_timer_mode_reg_r   <= `REG_RESET;
			timer_counter_mode_reg_r <= `REG_RESET;
			tca_reload_reg_r         <= `REG_RESET;
		end else if (ce_i) begin
			if (wr_basic_mode) begin
				basic_timer_mode_reg_r <= wdata_i;
			end
			if (wr_tca_mode) begin
				timer_counter_mode_reg_r <= wdata_i & `TM_RSVD_MASK;
			end
			if (wr_tca_reload) begin
				tca_reload_reg_r <= wdata_i;
			end
		end
	end

	// Low clock pin: two flops, then edge detect on the second
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_sync1_r <= 1'b0;
			low_sync2_r <= 1'b0;
			low_prev_r  <= 1'b0;
		end else if (ce_i) begin
			low_sync1_r <= low_clk_i;
			low_sync2_r <= low_sync1_r;
			low_prev_r  <= low_sync2_r;
		end
	end

	assign low_rise = low_sync2_r && !low_prev_r;

	// Half-second divider; the count register plays no part here
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rtc_phase_r   <= '0;
			rtc_timeout_r <= 1'b0;
		end else if (ce_i) begin
			rtc_timeout_r <= 1'b0;
			if (!(basic_timer_enable && realtime_select)) begin
				rtc_phase_r <= '0;
			end else if (low_rise) begin
				if (rtc_phase_r == RTC_LAST) begin
					rtc_phase_r   <= '0;
					rtc_timeout_r <= 1'b1;
				end else begin
					rtc_phase_r <= rtc_phase_r + RTC_W'(1);
				end
			end
		end
	end

	rate_prescaler u_basic_pre (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.run_i      (basic_timer_enable && !realtime_select),
		.src_tick_i (cpu_tick_i),
		.rate_i     (basic_rate_field),
		.fast_i     (1'b0),
		.step_o     (basic_step)
	);

	up_counter8 u_basic_cnt (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.run_i        (basic_timer_enable && !realtime_select),
		.step_i       (basic_step),
		.load_i       (wr_basic_count),
		.load_val_i   (wdata_i),
		.top_i        (`COUNT_TOP),
		.reload_en_i  (1'b0),
		.reload_val_i (8'h00),
		.count_o      (basic_timer_count_reg),
		.wrap_o       (basic_wrap)
	);

	// Fast source and octave shift follow the clock select
	rate_prescaler u_tca_pre (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.run_i      (tca_enable),
		.src_tick_i (tca_fast_clock_select ? osc_tick_i : cpu_tick_i),
		.rate_i     (tca_rate_field),
		.fast_i     (tca_fast_clock_select),
		.step_o     (tca_step)
	);

	// Pwm restarts each span from zero; reload applies outside pwm only
	assign tca_top = tca_pwm_enable ? span_top(tca_span) : `COUNT_TOP;

	up_counter8 u_tca_cnt (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.run_i        (tca_enable),
		.step_i       (tca_step),
		.load_i       (wr_tca_count),
		.load_val_i   (wdata_i),
		.top_i        (tca_top),
		.reload_en_i  (tca_auto_reload && !tca_pwm_enable),
		.reload_val_i (tca_reload_reg_r),
		.count_o      (tca_count_reg),
		.wrap_o       (tca_wrap)
	);

	assign basic_timeout = realtime_select ? rtc_timeout_r : basic_wrap;
	assign tca_timeout   = tca_wrap;

	// Interrupt flags: hardware set beats a software clear in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			basic_irq_enable_r  <= 1'b0;
			basic_irq_request_r <= 1'b0;
			tca_irq_enable_r    <= 1'b0;
			tca_irq_request_r   <= 1'b0;
		end else if (ce_i) begin
			if (wr_irq) begin
				basic_irq_enable_r <= wdata_i[`IRQ_BASIC_EN_BIT];
				tca_irq_enable_r   <= wdata_i[`IRQ_TCA_EN_BIT];
			end
			if (basic_timeout) begin
				basic_irq_request_r <= 1'b1;
			end else if (wr_irq) begin
				basic_irq_request_r <= wdata_i[`IRQ_BASIC_REQ_BIT];
			end
			if (tca_timeout) begin
				tca_irq_request_r <= 1'b1;
			end else if (wr_irq) begin
				tca_irq_request_r <= wdata_i[`IRQ_TCA_REQ_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			basic_irq_o <= 1'b0;
			tca_irq_o   <= 1'b0;
		end else if (ce_i) begin
			basic_irq_o <= basic_irq_request_r && basic_irq_enable_r;
			tca_irq_o   <= tca_irq_request_r && tca_irq_enable_r;
		end
	end

	// Green-mode wake pulse
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_o <= 1'b0;
		end else if (ce_i) begin
			wake_o <= green_mode_i && ((basic_timer_enable && basic_timeout)
			          || (tca_green_wake_enable && tca_timeout));
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tcb_fast_clock_select_o <= 1'b0;
		end else if (ce_i) begin
			tcb_fast_clock_select_o <= basic_timer_mode_reg_r[`BM_TCB_FAST_BIT];
		end
	end

	// Toggle level restarts low whenever toggle mode is left
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			toggle_level_r <= 1'b0;
		end else if (ce_i) begin
			if (!tca_toggle_output || tca_pwm_enable) begin
				toggle_level_r <= 1'b0;
			end else if (tca_timeout) begin
				toggle_level_r <= !toggle_level_r;
			end
		end
	end

	// Pin mux: pwm first, then toggle, else released to general I/O
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o                  <= 1'b0;
			toggle_output_pin_o    <= 1'b0;
			toggle_output_pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			pwm_o <= tca_pwm_enable && tca_enable && (tca_count_reg < tca_reload_reg_r);
			if (tca_pwm_enable) begin
				toggle_output_pin_o    <= tca_enable && (tca_count_reg < tca_reload_reg_r);
				toggle_output_pin_oe_o <= 1'b1;
			end else if (tca_toggle_output) begin
				toggle_output_pin_o    <= toggle_level_r;
				toggle_output_pin_oe_o <= 1'b1;
			end else begin
				toggle_output_pin_o    <= 1'b0;
				toggle_output_pin_oe_o <= 1'b0;
			end
		end
	end

	// Read port; the reload register is write only and reads zero
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (!re_i) begin
				rdata_o <= 8'h00;
			end else if (addr_i == `BASIC_MODE_OFF) begin
				rdata_o <= basic_timer_mode_reg_r;
			end else if (addr_i == `BASIC_COUNT_OFF) begin
				rdata_o <= basic_timer_count_reg;
			end else if (addr_i == `TCA_MODE_OFF) begin
				rdata_o <= timer_counter_mode_reg_r;
			end else if (addr_i == `TCA_COUNT_OFF) begin
				rdata_o <= tca_count_reg;
			end else if (addr_i == `IRQ_CTRL_OFF) begin
				rdata_o <= {4'h0, tca_irq_request_r, tca_irq_enable_r, basic_irq_request_r, basic_irq_enable_r};
			end else if (addr_i == `RTC_PHASE_OFF) begin
				rdata_o <= byte_t'(rtc_phase_r >> (RTC_W > 8 ? RTC_W - 8 : 0));
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

endmodule : timer_block

// File: dv/timer_block_asserts.sv
// Purpose: Port-level checks of the timer block
// Assumes: One clock domain; ce_i dropped only while no bus access runs
// Notes:   Bound to every timer_block instance
`timescale 1ns/1ns
module timer_block_asserts #(
	parameter int RTC_LOW_EDGES = 16384
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             green_mode_i,
	input  wire timer_pkg::byte_t addr_i,
	input  wire timer_pkg::byte_t wdata_i,
	input  wire logic             we_i,
	input  wire logic             re_i,
	input  wire timer_pkg::byte_t rdata_o,
	input  wire logic             basic_irq_o,
	input  wire logic             wake_o,
	input  wire logic             tcb_fast_clock_select_o,
	input  wire logic             toggle_output_pin_oe_o,
	input  wire logic             pwm_o
);
	import timer_pkg::*;
	logic mapped;
	assign mapped = addr_i inside {8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hc9, 8'hce};
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_RDATA_IDLE: assert property (!re_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	AST_UNMAPPED_READ: assert property (re_i && !mapped |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	AST_MODE_BIT3_ZERO: assert property (re_i && addr_i == 8'hda |=> !rdata_o[3])
		else $error("timer a mode bit 3 reads one");
	AST_TCB_SELECT: assert property (we_i && addr_i == 8'hd8 ##1 !we_i |=>
		tcb_fast_clock_select_o == $past(wdata_i[3], 2)) else $error("timer b select wrong");
	AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	AST_WAKE_IN_GREEN: assert property (wake_o |-> $past(green_mode_i))
		else $error("wake outside green mode");
	AST_PIN_RELEASED: assert property (we_i && addr_i == 8'hda && wdata_i[1:0] == 2'b00 ##1 !we_i
		|=> !toggle_output_pin_oe_o) else $error("pin still driven");
	AST_PWM_OFF: assert property (we_i && addr_i == 8'hda && !wdata_i[0] ##1 !we_i |=> !pwm_o)
		else $error("pwm active while disabled");
	AST_IRQ_MASKED: assert property (we_i && addr_i == 8'hc9 && !wdata_i[0] ##1 !we_i |=> !basic_irq_o)
		else $error("masked basic interrupt raised");
	AST_IRQ_HELD: assert property ($fell(basic_irq_o) |-> $past(we_i && addr_i == 8'hc9, 2))
		else $error("basic interrupt dropped without software");
endmodule : timer_block_asserts
bind timer_block timer_block_asserts #(.RTC_LOW_EDGES(RTC_LOW_EDGES)) i_timer_block_asserts (.ref_clk_i,
	.rst_i, .green_mode_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .basic_irq_o, .wake_o,
	.tcb_fast_clock_select_o, .toggle_output_pin_oe_o, .pwm_o);

// File: dv/timer_block_test.sv
// Purpose: Self-checking bench of the timer block
// Assumes: cpu tick every second cycle, osc tick every cycle
// Notes:   Half-second divider shortened to 8 low-clock edges
`timescale 1ns/1ns
module timer_block_test;
	import timer_pkg::*;
	localparam int LOW_EDGES = 8;
	logic  ref_clk_i = 0, rst_i = 1, ce_i = 1, cpu_tick_i = 0, osc_tick_i = 0, low_clk_i = 0, green_mode_i = 0;
	logic  we_i = 0, re_i = 0, basic_irq_o, tca_irq_o, wake_o, tcb_o, pin_o, pin_oe_o, pwm_o;
	byte_t addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v;
	int    errors = 0, total_checks = 0, cycles = 0;

	timer_block #(.RTC_LOW_EDGES(LOW_EDGES)) i_timer_block (.ref_clk_i, .rst_i, .ce_i, .cpu_tick_i,
		.osc_tick_i, .low_clk_i, .green_mode_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .basic_irq_o,
		.tca_irq_o, .wake_o, .tcb_fast_clock_select_o(tcb_o), .toggle_output_pin_o(pin_o),
		.toggle_output_pin_oe_o(pin_oe_o), .pwm_o);

	always #25 ref_clk_i = ~ref_clk_i;
	// Free-running crystal, phase unrelated to the system clock
	always #230 low_clk_i = ~low_clk_i;
	always @(posedge ref_clk_i) begin
		cpu_tick_i <= ~cpu_tick_i;
		osc_tick_i <= ~rst_i;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			close_out;
		end
	end

	task automatic close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out

	task automatic chk(input byte_t seen, input byte_t exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input byte_t a, input byte_t d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge ref_clk_i);
		we_i <= 1'b0;
	endtask : wr

	task automatic rd(input byte_t a, output byte_t d);
		@(posedge ref_clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge ref_clk_i);
		re_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	function automatic logic pick(input int s);
		case (s)
			0: return basic_irq_o;
			1: return tca_irq_o;
			2: return wake_o;
			3: return pin_o;
			default: return !pin_o;
		endcase
	endfunction : pick

	// Bounded wait; a hang counts as a mismatch
	task automatic wait_hi(input int s, output int n);
		n = 0;
		while (pick(s) !== 1'b1 && n < 3000) begin
			@(posedge ref_clk_i);
			#1 n++;
		end
		if (n >= 3000) chk(8'h01, 8'h00);
	endtask : wait_hi

	// Count follows its mode register in the map
	task automatic measure(input byte_t ma, input byte_t mv, input int s, output int n);
		wr(8'hc9, 8'h00);
		wr(ma + 8'h01, 8'hff);
		wr(8'hc9, 8'h05);
		wr(ma, mv);
		wait_hi(s, n);
		wr(ma, 8'h00);
	endtask : measure

	task automatic test_regs;
		byte_t a[4] = '{8'hd8, 8'hd9, 8'hda, 8'hc9};
		for (int i = 0; i < 4; i++) begin
			rd(a[i], v);
			chk(v, 8'h00);
		end
		wr(8'hd9, 8'ha5);
		rd(8'hd9, v);
		chk(v, 8'ha5);
		wr(8'hda, 8'h7f);
		rd(8'hda, v);
		chk(v, 8'h77);
		wr(8'hcd, 8'h55);
		wr(8'h00, 8'hff);
		rd(8'h00, v);
		chk(v, 8'h00);
		wr(8'hda, 8'h00);
		wr(8'hd8, 8'h08);
		repeat (2) @(posedge ref_clk_i);
		#1 chk({7'h00, tcb_o}, 8'h01);
		wr(8'hd8, 8'h00);
		$display("registers done");
	endtask : test_regs

	// Every rate code: basic on cpu, timer a on cpu, then on osc; latency must stay fixed
	task automatic test_rates;
		int n, d, r, base;
		for (int k = 0; k < 24; k++) begin
			r = 7 - (k % 8);
			if (k == 16) wr(8'hd8, 8'h04);
			d = (k < 16) ? (512 >> r) : (128 >> r);
			measure((k < 8) ? 8'hd8 : 8'hda, 8'h80 | byte_t'(r << 4), (k < 8) ? 0 : 1, n);
			if (r == 7) base = n - d;
			chk({7'h00, (n - d - base) inside {[-1:1]}}, 8'h01);
		end
		chk({7'h00, base inside {[2:10]}}, 8'h01);
		wr(8'hd8, 8'h00);
		$display("rates done");
	endtask : test_rates

	task automatic test_hold;
		byte_t w;
		wr(8'hd9, 8'h10);
		wr(8'hc9, 8'h01);
		wr(8'hd8, 8'h80);
		repeat (600) @(posedge ref_clk_i);
		wr(8'hd8, 8'h00);
		rd(8'hd9, v);
		chk(v, 8'h11);
		repeat (1200) @(posedge ref_clk_i);
		rd(8'hd9, w);
		chk(w, v);
		chk({7'h00, basic_irq_o}, 8'h00);
		$display("hold done");
	endtask : test_hold

	task automatic test_reload;
		int n;
		@(posedge ref_clk_i);
		green_mode_i <= 1'b1;
		wr(8'hd8, 8'h06);
		wr(8'hcd, 8'hf0);
		wr(8'hdb, 8'hff);
		wr(8'hc9, 8'h04);
		wr(8'hda, 8'hf6);
		wait_hi(2, n);
		chk({7'h00, n < 8}, 8'h01);
		wait_hi(3, n);
		chk({7'h00, pin_oe_o}, 8'h01);
		rd(8'hdb, v);
		chk({7'h00, v >= 8'hf0}, 8'h01);
		wait_hi(4, n);
		chk({7'h00, n inside {[10:18]}}, 8'h01);
		chk({7'h00, tca_irq_o}, 8'h01);
		wr(8'hda, 8'h00);
		wr(8'hc9, 8'h00);
		$display("reload done");
	endtask : test_reload

	// Rate and count set to slow values that must not matter
	task automatic test_rtc;
		int n;
		wr(8'hd9, 8'h00);
		wr(8'hc9, 8'h01);
		wr(8'hd8, 8'h81);
		wait_hi(2, n);
		wait_hi(0, n);
		wr(8'hc9, 8'h01);
		repeat (2) @(posedge ref_clk_i);
		wait_hi(0, n);
		chk({7'h00, (n + 4) inside {[72:76]}}, 8'h01);
		wr(8'hd8, 8'h00);
		wr(8'hc9, 8'h00);
		green_mode_i <= 1'b0;
		rd(8'hce, v);
		chk(v, 8'h00);
		$display("real-time done");
	endtask : test_rtc

	task automatic test_pwm;
		int hi, diff;
		logic held;
		hi = 0;
		diff = 0;
		wr(8'hd8, 8'h04);
		wr(8'hcd, 8'h40);
		wr(8'hdb, 8'h00);
		wr(8'hda, 8'hf3);
		repeat (300) @(posedge ref_clk_i);
		for (int i = 0; i < 256; i++) begin
			@(posedge ref_clk_i);
			#1 hi += (pwm_o === 1'b1);
			diff += (pin_o !== pwm_o);
		end
		chk(byte_t'(hi >> 1), 8'h40);
		chk(byte_t'(diff), 8'h00);
		chk({7'h00, pin_oe_o}, 8'h01);
		// Clock enable low must freeze the running pwm
		hi = 0;
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		@(posedge ref_clk_i);
		#1 held = pwm_o;
		repeat (100) begin
			@(posedge ref_clk_i);
			#1 hi += (pwm_o !== held);
		end
		@(posedge ref_clk_i);
		ce_i <= 1'b1;
		chk(byte_t'(hi), 8'h00);
		wr(8'hda, 8'h00);
		wr(8'hd8, 8'h00);
		$display("pwm done");
	endtask : test_pwm

	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		test_regs;
		test_rates;
		test_hold;
		test_reload;
		test_rtc;
		test_pwm;
		close_out;
	end
endmodule : timer_block_test
